/* dpmb_dev_model.sv */
/*
  Behavioural model of the shared-memory device seen from the host port.
  Assumes the host is the left port; the bench plays the right port.
*/
`timescale 1ns/1ps
module dpmb_dev_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic array_select_n,
  input wire logic token_select_n,
  input wire logic write_n,
  input wire logic drive_enable_n,
  input wire logic [13:0] addr,
  input wire logic [15:0] data_out,
  output logic [15:0] data_in,
  output logic contention_n,
  output logic mbox_int_n,
  input wire logic busy_n,
  input wire logic o_mb_we,
  input wire logic [15:0] o_data,
  input wire logic o_tok_we,
  input wire logic [2:0] o_tok_idx,
  input wire logic o_tok_val,
  output logic o_irq_n
);
  logic [15:0] mem [0:16383];
  logic [1:0] own_q [0:7];
  logic [7:0] pend_q [0:1];
  logic l_irq_q, r_irq_q, rdp_q, lv, tok_rd, arr_rd;
  logic [15:0] last_q, tok_rd_q, tv;
  // Model acts as master; the bench decides who lost
  assign contention_n = busy_n;
  assign mbox_int_n = ~l_irq_q;
  assign o_irq_n = ~r_irq_q;
  assign tok_rd = !token_select_n && !drive_enable_n && array_select_n;
  assign arr_rd = !array_select_n && !drive_enable_n;
  assign lv = own_q[addr[2:0]] != 2'h1;
  // Frozen after the first read cycle so the far port cannot change it
  assign tv = rdp_q ? tok_rd_q : {16{lv}};
  // Released bus shows the inverse of the last value, not a kind constant
  assign data_in = tok_rd ? tv : arr_rd ? mem[addr] : ~last_q;
  // Claim or release by side s (0 left, 1 right)
  task automatic tok(input int s, input logic [2:0] i, input logic v);
    if (!v) begin
      if (own_q[i] == 2'h0) own_q[i] <= 2'(s + 1);
      else if (own_q[i] != 2'(s + 1)) pend_q[s][i] <= 1'b1;
    end else if (own_q[i] == 2'(s + 1)) begin
      own_q[i] <= pend_q[1 - s][i] ? 2'(2 - s) : 2'h0;
      pend_q[1 - s][i] <= 1'b0;
    end else pend_q[s][i] <= 1'b0;
  endtask
  // Mailbox, array and token state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) own_q[i] <= 2'h0;
      pend_q[0] <= 8'h00;
      pend_q[1] <= 8'h00;
      l_irq_q <= 1'b0;
      r_irq_q <= 1'b0;
      rdp_q <= 1'b0;
      last_q <= 16'h0000;
    end else begin
      rdp_q <= tok_rd;
      if (!rdp_q) tok_rd_q <= {16{lv}};
      if (!drive_enable_n) last_q <= data_in;
      if (!token_select_n && array_select_n && !write_n) tok(0, addr[2:0], data_out[0]);
      if (o_tok_we) tok(1, o_tok_idx, o_tok_val);
      // Contended port's writes are dropped
      if (!array_select_n && !write_n && busy_n) begin
        mem[addr] <= data_out;
        if (addr == dpmb_pkg::MBOX_RIGHT_ADDR) r_irq_q <= 1'b1;
      end
      // Only an uncontended read of the own mailbox clears its interrupt
      if (arr_rd && busy_n && addr == dpmb_pkg::MBOX_LEFT_ADDR) begin
        l_irq_q <= 1'b0;
      end
      if (o_mb_we) mem[dpmb_pkg::MBOX_LEFT_ADDR] <= o_data;
      if (o_mb_we) l_irq_q <= 1'b1;
    end
  end
endmodule

/* dpmb_host.sv */
/*
  Host-side controller for one port of the shared memory device. Issues
  array reads and writes, mailbox traffic and token get/put sequences.
  Assumes asynchronous device pins sampled on clk, and the device keeps its
  own arbitration, mailbox and token behaviour.
*/
`timescale 1ns/1ps
// Behaviour
// - Delay slave writes until flag settles
// - Token access: token select low, array deselected
// - Gap with select inactive before read-back
// - Reading one means held elsewhere; write one withdraws
module dpmb_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic port_side,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [13:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_granted,
  output logic mbox_irq,
  output logic array_select_n,
  output logic token_select_n,
  output logic write_n,
  output logic drive_enable_n,
  output logic [13:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic contention_n,
  input wire logic mbox_int_n
);
  dpmb_pkg::dpmb_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] op_q, op_d;
  logic [13:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic ce_q, ce_d, tsel_q, tsel_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
  logic rv_q, rv_d, gr_q, gr_d, rdy_q, rdy_d, irq_q, irq_d;
  logic is_token;

  assign is_token = op_q[1];

  // Sequencer: settle, strobe, optional gap and token read-back
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    ce_d = 1'b1;
    tsel_d = 1'b1;
    we_d = 1'b1;
    oe_d = 1'b1;
    doe_d = 1'b0;
    rv_d = 1'b0;
    gr_d = gr_q;
    rdy_d = 1'b0;
    irq_d = ~mbox_int_n; // Interrupt from mailbox write by other port
    unique case (st_q)
      dpmb_pkg::ST_IDLE: begin
        rdy_d = 1'b1;
        if (cmd_valid && rdy_q) begin
          rdy_d = 1'b0;
          op_d = cmd_op;
          addr_d = cmd_addr;
          wdat_d = cmd_wdata;
          if (cmd_op[1]) begin
            // Only the low bits select a latch; the rest are zero
            addr_d = {{(dpmb_pkg::ADDR_W - dpmb_pkg::TOKEN_IDX_W){1'b0}},
                      cmd_addr[dpmb_pkg::TOKEN_IDX_W-1:0]};
            wdat_d = {{(dpmb_pkg::DATA_W-1){1'b0}},
                      cmd_op == dpmb_pkg::CMD_TOKEN_PUT};
          end
          cnt_d = dpmb_pkg::CNT_ZERO;
          st_d = dpmb_pkg::ST_SETTLE;
        end
      end
      dpmb_pkg::ST_SETTLE: begin
        // Select asserted, write held off until contention flag settles
        ce_d = is_token;
        tsel_d = ~is_token;
        cnt_d = cnt_q + dpmb_pkg::CNT_ONE;
        if (cnt_q >= 4'(dpmb_pkg::FLAG_SETTLE_CYC - 1)) begin
          cnt_d = dpmb_pkg::CNT_ZERO;
          st_d = dpmb_pkg::ST_STROBE;
        end
      end
      dpmb_pkg::ST_STROBE: begin
        ce_d = is_token;
        tsel_d = ~is_token;
        we_d = (op_q == dpmb_pkg::CMD_READ);
        oe_d = ~(op_q == dpmb_pkg::CMD_READ);
        doe_d = (op_q != dpmb_pkg::CMD_READ);
        cnt_d = cnt_q + dpmb_pkg::CNT_ONE;
        if (cnt_q >= 4'(dpmb_pkg::STROBE_CYC - 1)) begin
          cnt_d = dpmb_pkg::CNT_ZERO;
          rdat_d = data_in;
          // Busy at strobe end means the device ignored this access
          gr_d = contention_n;
          st_d = is_token ? dpmb_pkg::ST_GAP : dpmb_pkg::ST_DONE;
        end
      end
      dpmb_pkg::ST_GAP: begin
        // Token select inactive before read-back of the latch
        cnt_d = cnt_q + dpmb_pkg::CNT_ONE;
        if (cnt_q >= 4'(dpmb_pkg::GAP_CYC - 1)) begin
          cnt_d = dpmb_pkg::CNT_ZERO;
          st_d = dpmb_pkg::ST_TREAD;
        end
      end
      dpmb_pkg::ST_TREAD: begin
        tsel_d = 1'b0;
        oe_d = 1'b0;
        cnt_d = cnt_q + dpmb_pkg::CNT_ONE;
        if (cnt_q >= 4'(dpmb_pkg::VALID_CYC)) begin
          cnt_d = dpmb_pkg::CNT_ZERO;
          rdat_d = data_in;
          // Zero read back means this port owns the latch
          gr_d = ~data_in[0];
          st_d = dpmb_pkg::ST_DONE;
        end
      end
      dpmb_pkg::ST_DONE: begin
        rv_d = 1'b1; // One-cycle result strobe
        st_d = dpmb_pkg::ST_IDLE;
      end
      default: st_d = dpmb_pkg::ST_IDLE;
    endcase
  end

  // State and pin registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= dpmb_pkg::ST_IDLE;
      cnt_q <= dpmb_pkg::CNT_ZERO;
      op_q <= dpmb_pkg::CMD_READ;
      addr_q <= dpmb_pkg::ADDR_ZERO;
      wdat_q <= dpmb_pkg::DATA_ZERO;
      rdat_q <= dpmb_pkg::DATA_ZERO;
      ce_q <= 1'b1;
      tsel_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      doe_q <= 1'b0;
      rv_q <= 1'b0;
      gr_q <= 1'b0;
      rdy_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      ce_q <= ce_d;
      tsel_q <= tsel_d;
      we_q <= we_d;
      oe_q <= oe_d;
      doe_q <= doe_d;
      rv_q <= rv_d;
      gr_q <= gr_d;
      rdy_q <= rdy_d;
      irq_q <= irq_d;
    end
  end

  assign cmd_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign rsp_granted = gr_q;
  assign mbox_irq = irq_q;
  assign array_select_n = ce_q;
  assign token_select_n = tsel_q;
  assign write_n = we_q;
  assign drive_enable_n = oe_q;
  assign addr = addr_q;
  assign data_out = wdat_q;
  assign data_oe = doe_q;

  // Never select array and token latches together
  AST_SELECT_EXCL: assert property (@(posedge clk) disable iff (!nrst)
    !(!ce_q && !tsel_q)) else $error("array and token selected together");

  // Write strobe only after settle period
  AST_SETTLE_BEFORE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    $fell(we_q) |-> $past(!ce_q || !tsel_q, 3))
    else $error("write began before flag settled");

  // Token write data carries only bit zero
  AST_TOKEN_DATA: assert property (@(posedge clk) disable iff (!nrst)
    (!tsel_q && !we_q) |-> (wdat_q[15:1] == 15'h0000))
    else $error("token write drove upper data bits");

  // Token address holds only three low bits
  AST_TOKEN_ADDR: assert property (@(posedge clk) disable iff (!nrst)
    !tsel_q |-> (addr_q[13:3] == 11'h000)) else $error("token address high bits set");

  sequence s_tok_write_end;
    !tsel_q && !we_q ##1 we_q;
  endsequence
  // Gap with token select inactive after a token write
  AST_TOKEN_GAP: assert property (@(posedge clk) disable iff (!nrst)
    s_tok_write_end |-> tsel_q [*2]) else $error("token read-back gap too short");

  // Response follows a command within bounded time
  AST_RSP_BOUND: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_valid && cmd_ready) |-> ##[3:20] rsp_valid) else $error("no response in time");

  // Data lines driven exactly while the write strobe is low, never on reads
  AST_DRIVE_WITH_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    doe_q == !we_q) else $error("data drive and write strobe disagree");
endmodule

/* dpmb_pkg.sv */
/*
  Package for the host-side controller of one port of a two-port shared
  memory with mailbox words, contention flag and eight token latches.
  Assumes a 125 MHz system clock and asynchronous device pins sampled
  synchronously by the controller.
*/
package dpmb_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int TOKEN_IDX_W = 3;
  localparam int TOKEN_COUNT = 8;
  // Mailbox words at the top of the array
  localparam logic [13:0] MBOX_RIGHT_ADDR = 14'h3FFF;
  localparam logic [13:0] MBOX_LEFT_ADDR = 14'h3FFE;
  localparam logic [0:0] PORT_LEFT = 1'h0;
  localparam logic [0:0] PORT_RIGHT = 1'h1;
  // Timing in ns and derived cycle counts
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLAG_SETTLE_NS = 20;
  localparam int TOKEN_READ_GAP_NS = 10;
  localparam int DRIVE_TO_VALID_NS = 12;
  localparam int STROBE_NS = 15;
  localparam int FLAG_SETTLE_CYC = (FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (TOKEN_READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALID_CYC = (DRIVE_TO_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [13:0] ADDR_ZERO = 14'h0000;
  // Host command codes
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_TOKEN_GET = 2'h2;
  localparam logic [1:0] CMD_TOKEN_PUT = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_STROBE = 3'b010,
    ST_GAP = 3'b011,
    ST_TREAD = 3'b100,
    ST_DONE = 3'b101
  } dpmb_state_t;
endpackage

/* tb_dpmb_host.sv */
/*
  Bench for the host controller against the device model.
  Assumes the host is the left port; the bench drives the right port.
*/
`timescale 1ns/1ps
module tb_dpmb_host;
  logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, busy_n = 1'b1, o_mb_we = 1'b0;
  logic o_tok_we = 1'b0, o_tok_val = 1'b0, r_gr;
  logic [1:0] cmd_op = 2'h0;
  logic [2:0] o_tok_idx = 3'h0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [15:0] cmd_wdata = 16'h0000, o_data = 16'h0000, r_data;
  wire logic cmd_ready, rsp_valid, rsp_granted, mbox_irq, array_select_n, token_select_n;
  wire logic write_n, drive_enable_n, data_oe, contention_n, mbox_int_n, o_irq_n;
  wire logic [13:0] addr;
  wire logic [15:0] rsp_rdata, data_in, data_out;
  int num_errors = 0, compares = 0, cyc = 0;
  dpmb_host dpmb_host_inst (.clk, .nrst, .port_side(1'b0), .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_granted, .mbox_irq, .array_select_n,
    .token_select_n, .write_n, .drive_enable_n, .addr, .data_in, .data_out, .data_oe,
    .contention_n, .mbox_int_n);
  dpmb_dev_model dpmb_dev_model_inst (.clk, .nrst, .array_select_n, .token_select_n, .write_n,
    .drive_enable_n, .addr, .data_out, .data_in, .contention_n, .mbox_int_n, .busy_n, .o_mb_we,
    .o_data, .o_tok_we, .o_tok_idx, .o_tok_val, .o_irq_n);
  initial forever #4 clk = ~clk;
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task finish_test;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk_data(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One host command; entered just after a rising edge
  task cmd(input logic [1:0] op, input logic [13:0] a, input logic [15:0] d);
    int n;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    r_data = rsp_rdata;
    r_gr = rsp_granted;
  endtask
  // Right-port action: mailbox write or token write
  task other(input logic mb, input logic [2:0] i, input logic v, input logic [15:0] d);
    o_mb_we <= mb;
    o_tok_we <= !mb;
    o_tok_idx <= i;
    o_tok_val <= v;
    o_data <= d;
    @(posedge clk);
    o_mb_we <= 1'b0;
    o_tok_we <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task test_mbox;
    busy_n <= 1'b0;
    cmd(dpmb_pkg::CMD_WRITE, dpmb_pkg::MBOX_RIGHT_ADDR, 16'h1234);
    chk_bit(o_irq_n, 1'b1);
    chk_bit(r_gr, 1'b0);
    busy_n <= 1'b1;
    cmd(dpmb_pkg::CMD_WRITE, dpmb_pkg::MBOX_RIGHT_ADDR, 16'h1234);
    chk_bit(o_irq_n, 1'b0);
    chk_bit(r_gr, 1'b1);
    other(1'b1, 3'h0, 1'b0, 16'h5AA5);
    chk_bit(mbox_irq, 1'b1);
    cmd(dpmb_pkg::CMD_READ, dpmb_pkg::MBOX_RIGHT_ADDR, 16'h0000);
    repeat (3) @(posedge clk);
    chk_data(r_data, 16'h1234);
    chk_bit(mbox_irq, 1'b1);
    busy_n <= 1'b0;
    cmd(dpmb_pkg::CMD_READ, dpmb_pkg::MBOX_LEFT_ADDR, 16'h0000);
    repeat (3) @(posedge clk);
    chk_bit(mbox_irq, 1'b1);
    busy_n <= 1'b1;
    cmd(dpmb_pkg::CMD_READ, dpmb_pkg::MBOX_LEFT_ADDR, 16'h0000);
    repeat (3) @(posedge clk);
    chk_data(r_data, 16'h5AA5);
    chk_bit(mbox_irq, 1'b0);
    $display("test_mbox done");
  endtask
  task test_tokens;
    // High address bits set to show they are ignored
    for (int i = 0; i < 8; i++) begin
      cmd(dpmb_pkg::CMD_TOKEN_GET, 14'h3FF8 | 14'(i), 16'hFFFE);
      chk_data(r_data, 16'h0000);
      chk_bit(r_gr, 1'b1);
    end
    other(1'b0, 3'h3, 1'b0, 16'h0000);
    cmd(dpmb_pkg::CMD_TOKEN_PUT, 14'h0003, 16'h0000);
    chk_data(r_data, 16'hFFFF);
    cmd(dpmb_pkg::CMD_TOKEN_GET, 14'h0003, 16'h0000);
    chk_bit(r_gr, 1'b0);
    other(1'b0, 3'h3, 1'b1, 16'h0000);
    cmd(dpmb_pkg::CMD_TOKEN_GET, 14'h0003, 16'h0000);
    chk_data(r_data, 16'h0000);
    cmd(dpmb_pkg::CMD_TOKEN_PUT, 14'h0005, 16'h0000);
    chk_data(r_data, 16'hFFFF);
    $display("test_tokens done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    test_mbox();
    test_tokens();
    finish_test();
  end
endmodule
